// ### hw/lbc_pkg.sv
// package: register map, field positions and reset values of the lcd bias and pixel block
package lbc_pkg;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned NUM_COM   = 4;
  localparam int unsigned NUM_SEG   = 24;
  localparam int unsigned NUM_PIX_W = 12;

  // byte offsets
  localparam logic [7:0] OFF_MAIN   = 8'h00;
  localparam logic [7:0] OFF_REF    = 8'h04;
  localparam logic [7:0] OFF_LADDER = 8'h08;
  localparam logic [7:0] OFF_SEGEN  = 8'h0c;
  localparam logic [7:0] OFF_DIR    = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_PIX0   = 8'h40;
  localparam logic [7:0] OFF_PIXEND = 8'h70;

  // main control fields
  localparam int unsigned MAIN_MUX_LSB = 0;
  localparam int unsigned MAIN_WFT_BIT = 2;
  localparam int unsigned MAIN_EN_BIT  = 3;
  // reference control fields
  localparam int unsigned REF_CST_LSB  = 0;
  localparam int unsigned REF_IREN_BIT = 3;
  localparam int unsigned REF_SRC_BIT  = 4;
  localparam int unsigned REF_IRI_BIT  = 5;
  localparam int unsigned REF_VPIN_LSB = 8;
  // ladder control fields
  localparam int unsigned LAD_AT_LSB   = 0;

  localparam logic [31:0] MAIN_RST   = 32'h0000_0000;
  localparam logic [31:0] REF_RST    = 32'h0000_0000;
  localparam logic [31:0] LAD_RST    = 32'h0000_0000;
  localparam logic [23:0] SEGEN_RST  = 24'h00_0000;
  localparam logic [27:0] DIR_RST    = 28'hfff_ffff;

  // 32 khz tick from 100 mhz: 100e6/32768 truncates to 3051
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned SLOW_HZ     = 32_768;
  localparam int unsigned SLOW_DIV    = CLK_HZ / SLOW_HZ;
  localparam logic [11:0] SLOW_DIV_M1 = 12'(SLOW_DIV - 1);
  localparam logic [4:0]  TYPEA_LEN_M1 = 5'h0f;
  localparam logic [4:0]  TYPEB_LEN_M1 = 5'h1f;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lbc_pkg

// ### hw/lbc_top.sv
// lcd bias control, pin ownership and pixel storage with an axi4-lite slave
// What this block does
// [RULE1] a three-bit contrast step field drives a seven-tap ladder, all ones giving the deepest cut of about ten percent.
// [RULE2] while the module is inactive the contrast ladder switch is forced open whatever the step field holds.
// [RULE3] an enabled internal reference takes either the io supply or three times the fixed reference, as software picks.
// [RULE4] with no internal reference selected the contrast circuit is off and bias comes from the external pins.
// [RULE5] while the module is inactive the internal reference is off regardless of its enable.
// [RULE6] with fixed-reference source and auto-off set, the reference buffer is off whenever the ladder is in power mode b.
// [RULE7] the fixed reference enable is raised by the block itself whenever it is needed.
// [RULE8] each of the three external bias pins has its own enable and using them leaves the internal ladder alone.
// [RULE9] the two-bit common count select enables commons 0, 0-1, 0-2 or 0-3.
// [RULE10] an active common pin ignores its direction bit, otherwise the direction bit rules the pin.
// [RULE11] a pin is a segment driver only when its segment enable bit is one, else it keeps its alternate function.
// [RULE12] a set segment enable overrides that pin's direction bit.
// [RULE13] after reset every segment enable bit is cleared so pins are normal io.
// [RULE14] one pixel state bit per common and segment pair sets that pixel dark or clear.
// [RULE15] pixel bits not used by the glass remain ordinary read/write storage.
// [RULE16] each interval the ladder is in power mode a for the count in the a-interval field and in mode b for the rest.
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module lbc_top
  import lbc_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // analog control
  output logic [2:0]             contrast_step_field,
  output logic                   contrast_switch_closed,
  output logic                   ref_enable,
  output logic                   ref_src_fvr,
  output logic                   ref_buffer_on,
  output logic                   fixed_voltage_ref_req,
  output logic [2:0]             ext_bias_pins_en,
  output logic                   ladder_mode_a,
  // common and segment pins
  output logic [NUM_COM-1:0]     common_line_active,
  output logic [NUM_SEG-1:0]     segment_line_active,
  output logic [NUM_COM+NUM_SEG-1:0] pin_dir_effective,
  output logic [NUM_COM+NUM_SEG-1:0] pin_lcd_owned,
  output logic [NUM_COM*NUM_SEG-1:0] pixel_dark
);

  logic [31:0] main_reg;
  logic [31:0] ref_reg;
  logic [31:0] ladder_reg;
  logic [NUM_SEG-1:0] seg_en_reg;
  logic [NUM_COM+NUM_SEG-1:0] dir_reg;
  logic [7:0] pixel_state_regs [NUM_PIX_W];

  logic module_active_flag;
  logic waveform_type_bit;
  logic [1:0] common_count_select;
  logic [2:0] ladder_a_interval_field;
  logic ref_buffer_autooff_bit;
  logic int_ref_sel;

  assign module_active_flag      = main_reg[MAIN_EN_BIT];
  assign waveform_type_bit       = main_reg[MAIN_WFT_BIT];
  assign common_count_select     = main_reg[MAIN_MUX_LSB +: 2];
  assign ladder_a_interval_field = ladder_reg[LAD_AT_LSB +: 3];
  assign ref_buffer_autooff_bit  = ref_reg[REF_IRI_BIT];
  assign int_ref_sel             = ref_reg[REF_IREN_BIT];

  // axi write path: address and data latched independently
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              do_write;

  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign do_write      = aw_held_reg & w_held_reg & ~bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFF_MAIN) || (a == OFF_REF) || (a == OFF_LADDER) || (a == OFF_SEGEN) ||
                (a == OFF_DIR) || (a == OFF_STATUS) ||
                ((a >= OFF_PIX0) && (a < OFF_PIXEND) && (a[1:0] == 2'h0));
  endfunction : is_mapped

  // byte strobes honoured on every control word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) merge[i*8 +: 8] = d[i*8 +: 8];
    end
  endfunction : merge

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      // status is read only, a write there is refused
      bresp_reg  <= (is_mapped(aw_addr_reg) && aw_addr_reg != OFF_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // register write strobes, one per control word
  logic wr_main;
  logic wr_ref;
  logic wr_lad;
  logic wr_seg;
  logic wr_dir;
  assign wr_main = do_write && aw_addr_reg == OFF_MAIN;
  assign wr_ref  = do_write && aw_addr_reg == OFF_REF;
  assign wr_lad  = do_write && aw_addr_reg == OFF_LADDER;
  assign wr_seg  = do_write && aw_addr_reg == OFF_SEGEN;
  assign wr_dir  = do_write && aw_addr_reg == OFF_DIR;

  always_ff @(posedge aclk) begin
    if (!aresetn) main_reg <= MAIN_RST;
    else if (wr_main) main_reg <= merge(main_reg, w_data_reg, w_strb_reg) & 32'h0000_000f;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) ref_reg <= REF_RST;
    else if (wr_ref) ref_reg <= merge(ref_reg, w_data_reg, w_strb_reg) & 32'h0000_073f; // RULE8
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) ladder_reg <= LAD_RST;
    else if (wr_lad) ladder_reg <= merge(ladder_reg, w_data_reg, w_strb_reg) & 32'h0000_0007;
  end

  // narrow registers merge as a full word, then keep their own bits
  logic [31:0] seg_merged;
  logic [31:0] dir_merged;
  assign seg_merged = merge({8'h00, seg_en_reg}, w_data_reg, w_strb_reg);
  assign dir_merged = merge({4'h0, dir_reg}, w_data_reg, w_strb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) seg_en_reg <= SEGEN_RST; // RULE13
    else if (wr_seg) seg_en_reg <= seg_merged[NUM_SEG-1:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) dir_reg <= DIR_RST;
    else if (wr_dir) dir_reg <= dir_merged[NUM_COM+NUM_SEG-1:0];
  end

  // pixel storage, not reset: behaves as plain ram even where unused
  logic [3:0] pix_idx_w;
  logic       pix_hit_w;
  assign pix_idx_w = 4'(aw_addr_reg[5:2]);
  assign pix_hit_w = (aw_addr_reg >= OFF_PIX0) && (aw_addr_reg < OFF_PIXEND) && (aw_addr_reg[1:0] == 2'h0);
  // only byte 0 of a pixel word holds state
  always_ff @(posedge aclk) begin
    if (do_write && pix_hit_w && w_strb_reg[0]) begin
      pixel_state_regs[pix_idx_w] <= w_data_reg[7:0]; // RULE15
    end
  end

  // 32 khz tick and ladder interval sequencing
  logic [11:0] slow_cnt_reg;
  logic        slow_tick;
  logic [4:0]  phase_reg;
  logic [4:0]  phase_len_m1;
  logic [4:0]  a_count;

  assign slow_tick = (slow_cnt_reg == SLOW_DIV_M1);
  // divider held while inactive so the first interval after enable is whole
  always_ff @(posedge aclk) begin
    if (!aresetn || !module_active_flag || slow_tick) slow_cnt_reg <= '0; // RULE16
    else slow_cnt_reg <= slow_cnt_reg + 12'h001;
  end

  // type b intervals are twice as long, the a count is not doubled
  assign phase_len_m1 = waveform_type_bit ? TYPEB_LEN_M1 : TYPEA_LEN_M1;
  assign a_count      = {2'h0, ladder_a_interval_field};

  always_ff @(posedge aclk) begin
    if (!aresetn || !module_active_flag) phase_reg <= '0;
    else if (slow_tick) phase_reg <= (phase_reg == phase_len_m1) ? 5'h00 : phase_reg + 5'h01;
  end

  assign ladder_mode_a = module_active_flag && (phase_reg < a_count); // RULE16

  // analog control outputs
  assign contrast_step_field    = ref_reg[REF_CST_LSB +: 3]; // RULE1
  assign ref_enable             = int_ref_sel && module_active_flag; // RULE5
  assign ref_src_fvr            = ref_reg[REF_SRC_BIT]; // RULE3
  assign contrast_switch_closed = module_active_flag && int_ref_sel; // RULE2 RULE4
  assign ref_buffer_on          = ref_enable && ref_src_fvr &&
                                  !(ref_buffer_autooff_bit && !ladder_mode_a); // RULE6
  assign fixed_voltage_ref_req  = ref_enable && ref_src_fvr; // RULE7
  assign ext_bias_pins_en       = ref_reg[REF_VPIN_LSB +: 3]; // RULE8

  // pin ownership and pixel mapping
  genvar gc, gs;
  generate
    for (gc = 0; gc < NUM_COM; gc++) begin : g_com
      assign common_line_active[gc] = module_active_flag && (gc <= common_count_select); // RULE9
      assign pin_lcd_owned[gc]      = common_line_active[gc];
      assign pin_dir_effective[gc]  = common_line_active[gc] ? 1'b0 : dir_reg[gc]; // RULE10
      for (gs = 0; gs < NUM_SEG; gs++) begin : g_pix
        assign pixel_dark[gc*NUM_SEG+gs] = pixel_state_regs[gc*3+gs/8][gs%8]; // RULE14
      end
    end
    for (gs = 0; gs < NUM_SEG; gs++) begin : g_seg
      assign segment_line_active[gs]       = seg_en_reg[gs]; // RULE11
      assign pin_lcd_owned[NUM_COM+gs]     = seg_en_reg[gs];
      assign pin_dir_effective[NUM_COM+gs] = seg_en_reg[gs] ? 1'b0 : dir_reg[NUM_COM+gs]; // RULE12
    end
  endgenerate

  // axi read path, one cycle to answer
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rd_mux;
  logic [3:0]  pix_idx_r;
  logic [31:0] status_word;

  // status bits mirror the module enable and the live control outputs
  assign status_word   = {26'h0, ladder_mode_a, ref_buffer_on, fixed_voltage_ref_req,
                          ref_enable, contrast_switch_closed, module_active_flag};
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign pix_idx_r     = 4'(s_axi_araddr[5:2]);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (s_axi_araddr == OFF_MAIN) rd_mux = main_reg;
    else if (s_axi_araddr == OFF_REF) rd_mux = ref_reg;
    else if (s_axi_araddr == OFF_LADDER) rd_mux = ladder_reg;
    else if (s_axi_araddr == OFF_SEGEN) rd_mux = {8'h00, seg_en_reg};
    else if (s_axi_araddr == OFF_DIR) rd_mux = {4'h0, dir_reg};
    else if (s_axi_araddr == OFF_STATUS) rd_mux = status_word;
    else if (is_mapped(s_axi_araddr)) rd_mux = {24'h00_0000, pixel_state_regs[pix_idx_r]};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule : lbc_top

// ### dv/lbc_top_checker.sv
// concurrent checks on the ports of lbc_top
`timescale 1ns/1ps
module lbc_top_checker
  import lbc_pkg::*;
(
  // clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // register bus
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  // analog and pins
  input wire logic                contrast_switch_closed,
  input wire logic                ref_enable,
  input wire logic                ref_src_fvr,
  input wire logic                ref_buffer_on,
  input wire logic                fixed_voltage_ref_req,
  input wire logic                ladder_mode_a,
  input wire logic [NUM_COM-1:0]  common_line_active,
  input wire logic [NUM_SEG-1:0]  segment_line_active,
  input wire logic [27:0]         pin_dir_effective,
  input wire logic [27:0]         pin_lcd_owned
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // common 0 is driven exactly while the module is active
  chk_switch_gate: assert property (!common_line_active[0] |-> !contrast_switch_closed)
    else $error("contrast switch closed while inactive");
  chk_ref_gate: assert property (!common_line_active[0] |-> !ref_enable)
    else $error("internal reference on while inactive");
  chk_switch_noref: assert property (!ref_enable |-> !contrast_switch_closed)
    else $error("contrast switch closed without reference");
  chk_fvr_req: assert property (fixed_voltage_ref_req == (ref_enable && ref_src_fvr))
    else $error("fixed reference request mismatch");
  chk_buf_mode_a: assert property (fixed_voltage_ref_req && ladder_mode_a |-> ref_buffer_on)
    else $error("reference buffer off in mode a");
  chk_com_thermo: assert property (common_line_active inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
    else $error("common lines not contiguous from zero");
  chk_com_own: assert property (pin_lcd_owned[3:0] == common_line_active
    && (pin_dir_effective[3:0] & common_line_active) == 4'h0)
    else $error("common pin ownership wrong");
  chk_seg_own: assert property (pin_lcd_owned[27:4] == segment_line_active
    && (pin_dir_effective[27:4] & segment_line_active) == 24'h0)
    else $error("segment pin ownership wrong");
  chk_seg_reset: assert property ($rose(aresetn) |-> segment_line_active == 24'h0)
    else $error("segment enables not clear after reset");
  chk_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read response late");
endmodule : lbc_top_checker

bind lbc_top lbc_top_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .contrast_switch_closed, .ref_enable, .ref_src_fvr, .ref_buffer_on,
  .fixed_voltage_ref_req, .ladder_mode_a, .common_line_active, .segment_line_active,
  .pin_dir_effective, .pin_lcd_owned);

// ### dv/lbc_glass_model.sv
// lcd glass stand-in: counts pixels shown dark
`timescale 1ns/1ps
module lbc_glass_model
  import lbc_pkg::*;
(
  // lcd drive
  input wire logic [NUM_COM-1:0]         common_line_active,
  input wire logic [NUM_SEG-1:0]         segment_line_active,
  input wire logic [NUM_COM*NUM_SEG-1:0] pixel_dark,
  // observation
  output logic [6:0]                     n_dark
);
  always_comb begin
    n_dark = 7'h0;
    // a pixel only shows where its common and segment are both driven
    for (int c = 0; c < NUM_COM; c++) begin
      for (int s = 0; s < NUM_SEG; s++) begin
        if (common_line_active[c] && segment_line_active[s] && pixel_dark[c*NUM_SEG+s]) n_dark = n_dark + 7'h1;
      end
    end
  end
endmodule : lbc_glass_model

// ### dv/lbc_top_tb.sv
// self-checking bench for lbc_top
`timescale 1ns/1ps
module lbc_top_tb
  import lbc_pkg::*;
;
  logic              aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ladder_mode_a;
  logic              contrast_switch_closed, ref_enable, ref_src_fvr, ref_buffer_on, fixed_voltage_ref_req;
  logic [7:0]        s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb, common_line_active;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [2:0]        contrast_step_field, ext_bias_pins_en;
  logic [23:0]       segment_line_active;
  logic [27:0]       pin_dir_effective, pin_lcd_owned;
  logic [95:0]       pixel_dark;
  logic [6:0]        n_dark;
  int                n_errors = 0, n_tests = 0, cyc = 0;

  lbc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .contrast_step_field,
    .contrast_switch_closed, .ref_enable, .ref_src_fvr, .ref_buffer_on, .fixed_voltage_ref_req,
    .ext_bias_pins_en, .ladder_mode_a, .common_line_active, .segment_line_active, .pin_dir_effective,
    .pin_lcd_owned, .pixel_dark);
  lbc_glass_model u_glass (.common_line_active, .segment_line_active, .pixel_dark, .n_dark);

  task automatic results();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic cmp(input string nm, input logic [95:0] exp, input logic [95:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp

  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    // bready raised late so the slave must hold its answer
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    cmp("bresp", 96'(er), 96'(s_axi_bresp));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
    cmp("rdata", 96'(ed), 96'(s_axi_rdata));
    cmp("rresp", 96'(er), 96'(s_axi_rresp));
  endtask : rd

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ladder test alone needs about 23k cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_MAIN, MAIN_RST, RESP_OKAY);
    rd(OFF_SEGEN, 32'(SEGEN_RST), RESP_OKAY);
    rd(OFF_DIR, 32'(DIR_RST), RESP_OKAY);
    cmp("owned", 96'h0, 96'(pin_lcd_owned));
    $display("test reset done");
    wr(OFF_REF, 32'h1f, RESP_OKAY);
    cmp("cst", 96'h7, 96'(contrast_step_field));
    cmp("switch", 96'h0, 96'(contrast_switch_closed));
    cmp("refen", 96'h0, 96'(ref_enable));
    cmp("fvrreq", 96'h0, 96'(fixed_voltage_ref_req));
    for (int m = 0; m < 4; m++) begin
      wr(OFF_MAIN, 32'h8 | 32'(m), RESP_OKAY);
      cmp("com", 96'((1 << (m + 1)) - 1), 96'(common_line_active));
    end
    cmp("switch", 96'h1, 96'(contrast_switch_closed));
    cmp("refen", 96'h1, 96'(ref_enable));
    cmp("src", 96'h1, 96'(ref_src_fvr));
    cmp("fvrreq", 96'h1, 96'(fixed_voltage_ref_req));
    wr(OFF_REF, 32'h0f, RESP_OKAY);
    cmp("src", 96'h0, 96'(ref_src_fvr));
    cmp("fvrreq", 96'h0, 96'(fixed_voltage_ref_req));
    wr(OFF_REF, 32'h507, RESP_OKAY);
    cmp("switch", 96'h0, 96'(contrast_switch_closed));
    cmp("vpins", 96'h5, 96'(ext_bias_pins_en));
    wr(OFF_REF, 32'h70f, RESP_OKAY);
    cmp("vpins", 96'h7, 96'(ext_bias_pins_en));
    cmp("switch", 96'h1, 96'(contrast_switch_closed));
    $display("test gating done");
    wr(OFF_MAIN, 32'h9, RESP_OKAY);
    wr(OFF_SEGEN, 32'h80_0001, RESP_OKAY);
    wr(OFF_DIR, 32'haaa_aaaa, RESP_OKAY);
    cmp("owned", 96'h800_0013, 96'(pin_lcd_owned));
    cmp("dir", 96'h2aa_aaa8, 96'(pin_dir_effective));
    wr(OFF_PIX0, 32'ha5, RESP_OKAY);
    wr(OFF_PIX0 + 8'h2c, 32'h3c, RESP_OKAY);
    cmp("pix0", 96'ha5, 96'(pixel_dark[7:0]));
    cmp("pix11", 96'h3c, 96'(pixel_dark[95:88]));
    rd(OFF_PIX0 + 8'h2c, 32'h3c, RESP_OKAY);
    cmp("glass", 96'h1, 96'(n_dark));
    $display("test pins done");
    s_axi_wstrb <= 4'h2;
    wr(OFF_REF, 32'h0, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    cmp("vpins", 96'h0, 96'(ext_bias_pins_en));
    cmp("cst", 96'h7, 96'(contrast_step_field));
    cmp("switch", 96'h1, 96'(contrast_switch_closed));
    $display("test strobe done");
    wr(8'h20, 32'h1, RESP_SLVERR);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(OFF_STATUS, 32'h3f, RESP_SLVERR);
    rd(OFF_MAIN, 32'h9, RESP_OKAY);
    $display("test refused done");
    wr(OFF_MAIN, 32'h0, RESP_OKAY);
    wr(OFF_REF, 32'h38, RESP_OKAY);
    wr(OFF_MAIN, 32'hc, RESP_OKAY);
    cmp("modea", 96'h0, 96'(ladder_mode_a));
    cmp("buffer", 96'h0, 96'(ref_buffer_on));
    wr(OFF_MAIN, 32'h0, RESP_OKAY);
    wr(OFF_LADDER, 32'h7, RESP_OKAY);
    wr(OFF_MAIN, 32'h8, RESP_OKAY);
    cmp("modea", 96'h1, 96'(ladder_mode_a));
    cmp("buffer", 96'h1, 96'(ref_buffer_on));
    // sample half a tick clear of each boundary
    repeat (19838) @(posedge aclk);
    cmp("modea", 96'h1, 96'(ladder_mode_a));
    repeat (3052) @(posedge aclk);
    cmp("modea", 96'h0, 96'(ladder_mode_a));
    cmp("buffer", 96'h0, 96'(ref_buffer_on));
    $display("test ladder done");
    results();
  end
endmodule : lbc_top_tb
